// file: verilog/sfpe_seq.sv
// serial flash command sequencer: dual read, page program, erase
// assumes: host SPI pins are asynchronous and sampled here; the array
// answers a read address with data one SYS_CLK_I cycle later
// Notes on behaviour
// - dual read drives both output pins
// - eight dummy clocks after address, input ignored
// - even bits on io, odd on output
// - bits in on rise, out on fall
// - write enable sets the latch
// - program needs latch, address, one data byte
// - program refused while latch is clear
// - program data wraps inside the page
// - partial program leaves other bytes alone
// - program runs only on byte boundary
// - busy set during self-timed cycle
// - status read works while busy
// - latch cleared when a cycle finishes
// - program refused on protected page
// - sector erase sets 4K to ones
// - block erase sets 64K to ones
// - erase runs only on byte boundary
// - erase refused on protected area
// - two codes mean chip erase
// - chip erase needs select after eighth bit
// - chip erase refused if any protection
`include "sfpe_defs.svh"
module sfpe_seq
  import sfpe_pkg::*;
#(
  parameter int PROG_CYCLES = `SFPE_PROG_TIME_US * `SFPE_CLK_MHZ,
  parameter int SE_CYCLES = `SFPE_SECTOR_ERASE_TIME_US * `SFPE_CLK_MHZ,
  parameter int BE_CYCLES = `SFPE_BLOCK_ERASE_TIME_US * `SFPE_CLK_MHZ,
  parameter int CE_CYCLES = `SFPE_CHIP_ERASE_TIME_US * `SFPE_CLK_MHZ
)
(
  input wire logic SYS_CLK_I, // system clock
  input wire logic RESET_I, // synchronous reset
  input wire logic CE_I, // clock enable
  input wire logic CS_N_I, // chip select pin
  input wire logic SCK_I, // serial clock pin
  input wire logic SERIAL_IO_PIN_I, // io pin level
  output logic SERIAL_IO_PIN_O, // io pin drive
  output logic SERIAL_IO_PIN_OE_O, // io pin enable
  output logic SDO_O, // output pin drive
  output logic SDO_OE_O, // output pin enable
  input wire logic [2:0] BLOCK_PROTECT_BITS_I, // protection size
  input wire logic TOP_BOTTOM_SELECT_I, // protect from bottom
  output logic BUSY_O, // cycle running
  output logic WRITE_ENABLE_LATCH_O, // write permission
  output logic [23:0] MEM_RADDR_O, // array read address
  input wire logic [7:0] MEM_RDATA_I, // array read data
  output logic MEM_WE_O, // array program strobe
  output logic [23:0] MEM_WADDR_O, // array program address
  output logic [7:0] MEM_WDATA_O, // array program data
  output logic ERASE_REQ_O, // erase strobe
  output logic [1:0] ERASE_KIND_O, // sector, block or chip
  output logic [23:0] ERASE_ADDR_O // erase address
);

  function automatic logic is_prot(input logic [23:0] a,
                                   input logic [2:0] bp,
                                   input logic tb);
    logic [5:0] n;
    logic [5:0] b;
    n = (bp == 3'h0) ? 6'h00 :
        (bp >= `SFPE_BP_ALL) ? `SFPE_BLK_CNT :
        6'(6'h01 << (bp - 3'h1));
    b = {2'h0, a[`SFPE_BLK_MSB:`SFPE_BLK_LSB]};
    is_prot = tb ? (b < n) : ((b + n) >= `SFPE_BLK_CNT);
  endfunction : is_prot

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic cs_s1, cs_s2, cs_s3, sck_s1, sck_s2, sck_s3, io_s1, io_s2;
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      {cs_s1, cs_s2, cs_s3} <= 3'h7;
      {sck_s1, sck_s2, sck_s3, io_s1, io_s2} <= 5'h00;
    end
    else if (CE_I)
    begin
      {cs_s1, cs_s2, cs_s3} <= {CS_N_I, cs_s1, cs_s2};
      {sck_s1, sck_s2, sck_s3} <= {SCK_I, sck_s1, sck_s2};
      {io_s1, io_s2} <= {SERIAL_IO_PIN_I, io_s1};
    end
  end
  logic sck_rise, sck_fall, cs_rise;
  assign sck_rise = sck_s2 & ~sck_s3;
  assign sck_fall = ~sck_s2 & sck_s3;
  assign cs_rise = cs_s2 & ~cs_s3;

  //////////////////////////////////////////////////////////////////////
  // command front end
  sfpe_state_t state_reg, state_next;
  sfpe_op_t op_reg, op_next, launch;
  logic [7:0] cmd_reg, cmd_next, sh_reg, sh_next, in_byte, obyte_reg;
  logic [7:0] obyte_next, byte_v, pidx_reg, pidx_next, pb_idx;
  logic [23:0] addr_reg, addr_next, addr_full;
  logic [4:0] bit_cnt_reg, bit_cnt_next;
  logic [2:0] out_cnt_reg, out_cnt_next;
  logic got_reg, got_next, pb_we, pb_clr;
  logic sio_reg, sio_next, sio_oe_reg, sio_oe_next;
  logic sdo_reg, sdo_next, sdo_oe_reg, sdo_oe_next;
  logic busy_reg, wel_reg;
  logic [7:0] pb_data [256];
  logic [255:0] pb_vld;

  assign in_byte = {sh_reg[6:0], io_s2};
  assign addr_full = {addr_reg[22:0], io_s2};

  always_comb
  begin
    state_next = state_reg;
    op_next = op_reg;
    cmd_next = cmd_reg;
    sh_next = sh_reg;
    addr_next = addr_reg;
    bit_cnt_next = bit_cnt_reg;
    out_cnt_next = out_cnt_reg;
    obyte_next = obyte_reg;
    pidx_next = pidx_reg;
    got_next = got_reg;
    sio_next = sio_reg;
    sio_oe_next = sio_oe_reg;
    sdo_next = sdo_reg;
    sdo_oe_next = sdo_oe_reg;
    launch = OP_NONE;
    pb_we = 1'b0;
    pb_clr = 1'b0;
    pb_idx = addr_reg[7:0] + pidx_reg;
    byte_v = obyte_reg;
    if (cs_s2)
    begin
      state_next = ST_CMD;
      bit_cnt_next = 5'h00;
      sio_oe_next = 1'b0;
      sdo_oe_next = 1'b0;
      if (cs_rise && state_reg == ST_TAIL)
        launch = op_reg;
      else if (cs_rise && state_reg == ST_PDATA && got_reg &&
               bit_cnt_reg == 5'h00)
        launch = OP_PROG;
    end
    else if (sck_fall &&
             (state_reg == ST_DREAD || state_reg == ST_STATUS))
    begin
      out_cnt_next = out_cnt_reg + 3'h1;
      if (state_reg == ST_DREAD)
      begin
        if (out_cnt_reg[1:0] == 2'h0)
        begin
          byte_v = MEM_RDATA_I;
          addr_next = addr_reg + 24'h000001;
        end
        sio_next = byte_v[6];
        obyte_next = byte_v << 2;
        sio_oe_next = 1'b1;
      end
      else
      begin
        if (out_cnt_reg == 3'h0)
          byte_v = {2'h0, TOP_BOTTOM_SELECT_I, BLOCK_PROTECT_BITS_I,
                    wel_reg, busy_reg};
        obyte_next = byte_v << 1;
      end
      sdo_next = byte_v[7];
      sdo_oe_next = 1'b1;
    end
    else if (sck_rise)
    begin
      sh_next = in_byte;
      bit_cnt_next = bit_cnt_reg + 5'h01;
      case (state_reg)
        ST_CMD:
        begin
          if (bit_cnt_reg == `SFPE_BYTE_LAST)
          begin
            cmd_next = in_byte;
            bit_cnt_next = 5'h00;
            out_cnt_next = 3'h0;
            op_next = OP_NONE;
            state_next = ST_IGNORE;
            if (busy_reg && in_byte != `SFPE_CMD_RDSR)
              state_next = ST_IGNORE;
            else if (in_byte == `SFPE_CMD_RDSR)
              state_next = ST_STATUS;
            else if (in_byte == `SFPE_CMD_DREAD)
              state_next = ST_ADDR;
            else if (in_byte == `SFPE_CMD_WREN)
            begin
              state_next = ST_TAIL;
              op_next = OP_WREN;
            end
            else if (in_byte == `SFPE_CMD_WRDI)
            begin
              state_next = ST_TAIL;
              op_next = OP_WRDI;
            end
            else if (wel_reg && (in_byte == `SFPE_CMD_PROG ||
                     in_byte == `SFPE_CMD_SE || in_byte == `SFPE_CMD_BE))
            begin
              state_next = ST_ADDR;
              op_next = (in_byte == `SFPE_CMD_PROG) ? OP_PROG :
                        (in_byte == `SFPE_CMD_SE) ? OP_SE : OP_BE;
            end
            else if (wel_reg && BLOCK_PROTECT_BITS_I == 3'h0 &&
                     (in_byte == `SFPE_CMD_CE1 ||
                      in_byte == `SFPE_CMD_CE2))
            begin
              state_next = ST_TAIL;
              op_next = OP_CE;
            end
          end
        end
        ST_ADDR:
        begin
          addr_next = addr_full;
          if (bit_cnt_reg == `SFPE_ADDR_LAST)
          begin
            bit_cnt_next = 5'h00;
            if (cmd_reg == `SFPE_CMD_DREAD)
              state_next = ST_DUMMY;
            else if (is_prot(addr_full, BLOCK_PROTECT_BITS_I,
                             TOP_BOTTOM_SELECT_I))
              state_next = ST_IGNORE;
            else if (op_reg == OP_PROG)
            begin
              state_next = ST_PDATA;
              pb_clr = 1'b1;
              pidx_next = 8'h00;
              got_next = 1'b0;
            end
            else
              state_next = ST_TAIL;
          end
        end
        ST_DUMMY:
          if (bit_cnt_reg == `SFPE_BYTE_LAST)
          begin
            state_next = ST_DREAD;
            out_cnt_next = 3'h0;
          end
        ST_PDATA:
          if (bit_cnt_reg == `SFPE_BYTE_LAST)
          begin
            pb_we = 1'b1;
            pidx_next = pidx_reg + 8'h01;
            got_next = 1'b1;
            bit_cnt_next = 5'h00;
          end
        ST_TAIL: state_next = ST_IGNORE;
        default: ;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      state_reg <= ST_CMD;
      op_reg <= OP_NONE;
      cmd_reg <= 8'h00;
      sh_reg <= 8'h00;
      addr_reg <= 24'h000000;
      bit_cnt_reg <= 5'h00;
      out_cnt_reg <= 3'h0;
      obyte_reg <= 8'h00;
      pidx_reg <= 8'h00;
      got_reg <= 1'b0;
      {sio_reg, sio_oe_reg, sdo_reg, sdo_oe_reg} <= 4'h0;
    end
    else if (CE_I)
    begin
      state_reg <= state_next;
      op_reg <= op_next;
      cmd_reg <= cmd_next;
      sh_reg <= sh_next;
      addr_reg <= addr_next;
      bit_cnt_reg <= bit_cnt_next;
      out_cnt_reg <= out_cnt_next;
      obyte_reg <= obyte_next;
      pidx_reg <= pidx_next;
      got_reg <= got_next;
      {sio_reg, sio_oe_reg, sdo_reg, sdo_oe_reg} <=
        {sio_next, sio_oe_next, sdo_next, sdo_oe_next};
    end
  end

  //////////////////////////////////////////////////////////////////////
  // page buffer: only bytes received are marked for programming
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
      pb_vld <= '0;
    else if (CE_I)
    begin
      if (pb_clr)
        pb_vld <= '0;
      if (pb_we)
      begin
        pb_data[pb_idx] <= in_byte;
        pb_vld[pb_idx] <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // self-timed program and erase engine
  logic busy_next, wel_next, run_reg, run_next;
  logic [8:0] pw_reg, pw_next;
  logic [31:0] tmr_reg, tmr_next;
  logic we_reg, we_next, er_reg, er_next;
  logic [1:0] kind_reg, kind_next;
  logic [23:0] eaddr_reg, eaddr_next, waddr_reg, waddr_next;
  logic [7:0] wdata_reg, wdata_next;

  always_comb
  begin
    busy_next = busy_reg;
    wel_next = wel_reg;
    run_next = run_reg;
    pw_next = pw_reg;
    tmr_next = tmr_reg;
    we_next = 1'b0;
    er_next = 1'b0;
    kind_next = kind_reg;
    eaddr_next = eaddr_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    case (launch)
      OP_WREN: wel_next = 1'b1;
      OP_WRDI: wel_next = 1'b0;
      OP_PROG:
      begin
        busy_next = 1'b1;
        run_next = 1'b1;
        pw_next = 9'h000;
        tmr_next = 32'(PROG_CYCLES);
      end
      OP_SE, OP_BE, OP_CE:
      begin
        busy_next = 1'b1;
        er_next = 1'b1;
        eaddr_next = addr_reg;
        kind_next = (launch == OP_SE) ? `SFPE_KIND_SECTOR :
                    (launch == OP_BE) ? `SFPE_KIND_BLOCK : `SFPE_KIND_CHIP;
        tmr_next = (launch == OP_SE) ? 32'(SE_CYCLES) :
                   (launch == OP_BE) ? 32'(BE_CYCLES) : 32'(CE_CYCLES);
      end
      default:
        if (busy_reg)
        begin
          if (run_reg)
          begin
            if (pw_reg[8])
              run_next = 1'b0;
            else
            begin
              we_next = pb_vld[pw_reg[7:0]];
              waddr_next = {addr_reg[23:8], pw_reg[7:0]};
              wdata_next = pb_data[pw_reg[7:0]];
              pw_next = pw_reg + 9'h001;
            end
          end
          if (tmr_reg != 32'h00000000)
            tmr_next = tmr_reg - 32'h00000001;
          else if (!run_reg)
          begin
            busy_next = 1'b0;
            wel_next = 1'b0;
          end
        end
    endcase
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (RESET_I)
    begin
      {busy_reg, wel_reg, run_reg, we_reg, er_reg} <= 5'h00;
      pw_reg <= 9'h000;
      tmr_reg <= 32'h00000000;
      kind_reg <= 2'h0;
      eaddr_reg <= 24'h000000;
      waddr_reg <= 24'h000000;
      wdata_reg <= 8'h00;
    end
    else if (CE_I)
    begin
      {busy_reg, wel_reg, run_reg, we_reg, er_reg} <=
        {busy_next, wel_next, run_next, we_next, er_next};
      pw_reg <= pw_next;
      tmr_reg <= tmr_next;
      kind_reg <= kind_next;
      eaddr_reg <= eaddr_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
    end
  end

  assign SERIAL_IO_PIN_O = sio_reg;
  assign SERIAL_IO_PIN_OE_O = sio_oe_reg;
  assign SDO_O = sdo_reg;
  assign SDO_OE_O = sdo_oe_reg;
  assign BUSY_O = busy_reg;
  assign WRITE_ENABLE_LATCH_O = wel_reg;
  assign MEM_RADDR_O = addr_reg;
  assign MEM_WE_O = we_reg;
  assign MEM_WADDR_O = waddr_reg;
  assign MEM_WDATA_O = wdata_reg;
  assign ERASE_REQ_O = er_reg;
  assign ERASE_KIND_O = kind_reg;
  assign ERASE_ADDR_O = eaddr_reg;

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I || !CE_I);
  sequence s_code_in;
    !cs_s2 && sck_rise && state_reg == ST_CMD &&
    bit_cnt_reg == `SFPE_BYTE_LAST;
  endsequence
  AST_WREN_SETS: assert property (
    launch == OP_WREN |=> wel_reg) else $error("latch not set");
  AST_PROG_NO_WEL: assert property (
    s_code_in and (in_byte == `SFPE_CMD_PROG && !wel_reg)
    |=> state_reg == ST_IGNORE) else $error("program taken");
  AST_BUSY_IGNORE: assert property (
    s_code_in and (busy_reg && in_byte != `SFPE_CMD_RDSR)
    |=> state_reg == ST_IGNORE) else $error("busy took command");
  AST_STATUS_BUSY: assert property (
    s_code_in and (in_byte == `SFPE_CMD_RDSR)
    |=> state_reg == ST_STATUS) else $error("status refused");
  AST_BUSY_START: assert property (
    launch inside {OP_PROG, OP_SE, OP_BE, OP_CE} |=> busy_reg ##1 busy_reg)
    else $error("busy not raised");
  AST_WEL_DONE: assert property (
    $fell(busy_reg) |-> !wel_reg) else $error("latch kept");
  AST_CE_PROT: assert property (
    s_code_in and (in_byte == `SFPE_CMD_CE1 && BLOCK_PROTECT_BITS_I != 3'h0)
    |=> state_reg == ST_IGNORE) else $error("chip erase taken");
  AST_TAIL_DROP: assert property (
    !cs_s2 && sck_rise && state_reg == ST_TAIL
    |=> state_reg == ST_IGNORE ##1 launch == OP_NONE)
    else $error("late bits kept");
  AST_DUAL_OUT: assert property (
    !cs_s2 && sck_fall && state_reg == ST_DREAD
    |=> SERIAL_IO_PIN_OE_O && SDO_OE_O) else $error("single pin out");
  AST_SE_PULSE: assert property (
    launch == OP_SE |=> ERASE_REQ_O && ERASE_KIND_O == `SFPE_KIND_SECTOR
    ##1 !ERASE_REQ_O) else $error("sector erase missing");

endmodule : sfpe_seq

// file: verilog/sfpe_defs.svh
// constants of the serial flash command sequencer
// assumes: included by the sequencer only
`ifndef SFPE_DEFS_SVH
`define SFPE_DEFS_SVH
`define SFPE_CMD_WREN 8'h06
`define SFPE_CMD_WRDI 8'h04
`define SFPE_CMD_RDSR 8'h05
`define SFPE_CMD_DREAD 8'h3B
`define SFPE_CMD_PROG 8'h02
`define SFPE_CMD_SE 8'h20
`define SFPE_CMD_BE 8'hD8
`define SFPE_CMD_CE1 8'hC7
`define SFPE_CMD_CE2 8'h60
`define SFPE_ADDR_LAST 5'h17
`define SFPE_BYTE_LAST 5'h07
`define SFPE_BLK_MSB 19
`define SFPE_BLK_LSB 16
`define SFPE_BLK_CNT 6'h10
`define SFPE_BP_ALL 3'h5
`define SFPE_KIND_SECTOR 2'h0
`define SFPE_KIND_BLOCK 2'h1
`define SFPE_KIND_CHIP 2'h2
`define SFPE_CLK_MHZ 125
`define SFPE_PROG_TIME_US 1000
`define SFPE_SECTOR_ERASE_TIME_US 100000
`define SFPE_BLOCK_ERASE_TIME_US 1000000
`define SFPE_CHIP_ERASE_TIME_US 10000000
`endif

// file: verilog/sfpe_pkg.sv
// types of the serial flash command sequencer
// assumes: nothing beyond the constants header
package sfpe_pkg;
  typedef enum logic [2:0] {
    ST_CMD = 3'h0,
    ST_ADDR = 3'h1,
    ST_DUMMY = 3'h3,
    ST_DREAD = 3'h2,
    ST_PDATA = 3'h6,
    ST_TAIL = 3'h7,
    ST_STATUS = 3'h5,
    ST_IGNORE = 3'h4
  } sfpe_state_t;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_WREN = 3'h1,
    OP_WRDI = 3'h2,
    OP_PROG = 3'h3,
    OP_SE = 3'h4,
    OP_BE = 3'h5,
    OP_CE = 3'h6
  } sfpe_op_t;
endpackage : sfpe_pkg

// file: dv/sfpe_host.sv
// host-side SPI controller model for the flash command sequencer
// assumes: tasks are called from one process; clk_i is the system clock
module sfpe_host (
  input wire logic clk_i, // system clock
  input wire logic sdo_i, // output pin level
  input wire logic io_i, // resolved io pin level
  output logic cs_n_o, // chip select, low active
  output logic sck_o, // serial clock, idles low
  output logic io_o, // io pin drive value
  output logic io_oe_o // io pin drive enable
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PH = 5; // system cycles per serial clock phase
  initial
  begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    io_o = 1'b0;
    io_oe_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic wt(input int n);
    repeat (n) @(negedge clk_i);
  endtask : wt
  task automatic open_frame;
    cs_n_o = 1'b0;
    io_oe_o = 1'b1;
    wt(PH);
  endtask : open_frame
  // top n bits of b, msb first on rising sck; rel frees io before last fall when n is 8
  task automatic put_bits(input logic [7:0] b, input int n, input bit rel);
    for (int i = 7; i > 7 - n; i--)
    begin
      io_o = b[i];
      wt(PH);
      sck_o = 1'b1;
      wt(PH);
      if (rel && i == 0)
      begin
        io_oe_o = 1'b0;
        wt(1);
      end
      sck_o = 1'b0;
    end
  endtask : put_bits
  task automatic close_frame;
    wt(PH);
    cs_n_o = 1'b1;
    io_oe_o = 1'b0;
    wt(2 * PH);
  endtask : close_frame
  // one byte on sdo alone, or on sdo and io pairs
  task automatic get_byte(input bit dual, output logic [7:0] b);
    for (int i = 0; i < (dual ? 4 : 8); i++)
    begin
      wt(PH);
      b = dual ? {b[5:0], sdo_i, io_i} : {b[6:0], sdo_i};
      sck_o = 1'b1;
      wt(PH);
      sck_o = 1'b0;
    end
  endtask : get_byte
endmodule : sfpe_host

// file: dv/sfpe_seq_tb_top.sv
// self-checking bench for the serial flash command sequencer
// assumes: sfpe_host drives the pins; array read data from a local model
module sfpe_seq_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] bp = 3'h0;
  logic tsel = 1'b0;
  logic ce = 1'b1;
  logic cs_n, sck, h_io, h_oe, io_dut, io_oe, sdo, sdo_oe, busy, write_enable_latch;
  logic we, ereq, io_wire, sdo_wire;
  logic idle_tgl = 1'b0;
  logic [23:0] raddr, waddr, eaddr, er_addr;
  logic [7:0] wdata;
  logic [7:0] rdata = 8'h00;
  logic [1:0] ekind, er_kind;
  logic [7:0] wmem [logic [23:0]];
  logic [7:0] codes [4] = '{8'h20, 8'hD8, 8'hC7, 8'h60};
  int cyc = 0;
  int n_mismatch = 0;
  int cmp_count = 0;
  int wr_cnt = 0;
  int er_cnt = 0;
  always #4 sys_clk = ~sys_clk;
  // released lines wander instead of holding the last value
  assign io_wire = io_oe ? io_dut : (h_oe ? h_io : idle_tgl);
  assign sdo_wire = sdo_oe ? sdo : idle_tgl;
  sfpe_host u_sfpe_host (.clk_i(sys_clk), .sdo_i(sdo_wire), .io_i(io_wire),
    .cs_n_o(cs_n), .sck_o(sck), .io_o(h_io), .io_oe_o(h_oe));
  sfpe_seq #(.PROG_CYCLES(600), .SE_CYCLES(20), .BE_CYCLES(20),
    .CE_CYCLES(20)) u_sfpe_seq (.SYS_CLK_I(sys_clk), .RESET_I(reset),
    .CE_I(ce), .CS_N_I(cs_n), .SCK_I(sck), .SERIAL_IO_PIN_I(io_wire),
    .SERIAL_IO_PIN_O(io_dut), .SERIAL_IO_PIN_OE_O(io_oe), .SDO_O(sdo),
    .SDO_OE_O(sdo_oe), .BLOCK_PROTECT_BITS_I(bp),
    .TOP_BOTTOM_SELECT_I(tsel), .BUSY_O(busy),
    .WRITE_ENABLE_LATCH_O(write_enable_latch), .MEM_RADDR_O(raddr), .MEM_RDATA_I(rdata),
    .MEM_WE_O(we), .MEM_WADDR_O(waddr), .MEM_WDATA_O(wdata),
    .ERASE_REQ_O(ereq), .ERASE_KIND_O(ekind), .ERASE_ADDR_O(eaddr));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rd_val(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction : rd_val
  always @(posedge sys_clk)
  begin
    idle_tgl <= ~idle_tgl;
    rdata <= rd_val(raddr);
    cyc <= cyc + 1;
    if (we === 1'b1)
    begin
      wr_cnt++;
      wmem[waddr] = wdata;
    end
    if (ereq === 1'b1)
    begin
      er_cnt++;
      er_kind = ekind;
      er_addr = eaddr;
    end
    if (cyc == 80000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [23:0] e,
    input logic [23:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic close_out;
    $display("counts: %0d mismatches, %0d compares", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  task automatic hdr(input logic [7:0] c, input logic [23:0] a, input bit wa);
    u_sfpe_host.open_frame();
    u_sfpe_host.put_bits(c, 8, 1'b0);
    if (wa)
      for (int i = 2; i >= 0; i--)
        u_sfpe_host.put_bits(a[8 * i +: 8], 8, 1'b0);
  endtask : hdr
  task automatic simple(input logic [7:0] c);
    hdr(c, 24'h0, 1'b0);
    u_sfpe_host.close_frame();
  endtask : simple
  task automatic clr;
    wr_cnt = 0;
    er_cnt = 0;
    wmem.delete();
  endtask : clr
  task automatic wait_idle;
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 3000)
    begin
      @(negedge sys_clk);
      k++;
    end
    chk("busy clear", 24'h0, busy);
  endtask : wait_idle
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [7:0] b;
    repeat (12) @(negedge sys_clk);
    reset = 1'b0;
    u_sfpe_host.wt(3);
    chk("wel reset", 24'h0, write_enable_latch);
    clr();
    hdr(8'h02, 24'h000110, 1'b1);
    u_sfpe_host.put_bits(8'h55, 8, 1'b0);
    u_sfpe_host.close_frame();
    u_sfpe_host.wt(20);
    chk("refused writes", 24'h0, wr_cnt);
    chk("refused busy", 24'h0, busy);
    $display("test program_without_latch done");
    simple(8'h06);
    chk("wel set", 24'h1, write_enable_latch);
    hdr(8'h02, 24'h000110, 1'b1);
    u_sfpe_host.put_bits(8'h11, 8, 1'b0);
    u_sfpe_host.put_bits(8'h22, 8, 1'b0);
    u_sfpe_host.close_frame();
    hdr(8'h05, 24'h0, 1'b0);
    u_sfpe_host.get_byte(1'b0, b);
    u_sfpe_host.close_frame();
    chk("status busy", 24'h1, b[0]);
    chk("status wel", 24'h1, b[1]);
    simple(8'h04);
    chk("busy held", 24'h1, busy);
    chk("wel kept", 24'h1, write_enable_latch);
    wait_idle();
    chk("wel after program", 24'h0, write_enable_latch);
    chk("partial writes", 24'h2, wr_cnt);
    chk("byte 110", 24'h11, wmem[24'h000110]);
    chk("byte 111", 24'h22, wmem[24'h000111]);
    $display("test partial_program done");
    clr();
    simple(8'h06);
    hdr(8'h02, 24'h0002FE, 1'b1);
    for (int k = 0; k < 258; k++)
      u_sfpe_host.put_bits(8'(k), 8, 1'b0);
    u_sfpe_host.close_frame();
    wait_idle();
    chk("wrap writes", 24'h100, wr_cnt);
    chk("byte 2FE", 24'h00, wmem[24'h0002FE]);
    chk("byte 2FF", 24'h01, wmem[24'h0002FF]);
    chk("byte 200", 24'h02, wmem[24'h000200]);
    chk("byte 2FD", 24'hFF, wmem[24'h0002FD]);
    $display("test page_wrap done");
    clr();
    simple(8'h06);
    hdr(8'h02, 24'h000300, 1'b1);
    for (int k = 0; k < 256; k++)
      u_sfpe_host.put_bits(8'(k), 8, 1'b0);
    u_sfpe_host.close_frame();
    wait_idle();
    chk("page writes", 24'h100, wr_cnt);
    chk("byte 300", 24'h00, wmem[24'h000300]);
    chk("byte 3FF", 24'hFF, wmem[24'h0003FF]);
    $display("test full_page done");
    clr();
    simple(8'h06);
    hdr(8'h02, 24'h000400, 1'b1);
    u_sfpe_host.put_bits(8'h77, 8, 1'b0);
    u_sfpe_host.put_bits(8'hE0, 3, 1'b0);
    u_sfpe_host.close_frame();
    hdr(8'h20, 24'h001000, 1'b1);
    u_sfpe_host.put_bits(8'h80, 1, 1'b0);
    u_sfpe_host.close_frame();
    hdr(8'hC7, 24'h0, 1'b0);
    u_sfpe_host.put_bits(8'h80, 1, 1'b0);
    u_sfpe_host.close_frame();
    u_sfpe_host.wt(20);
    chk("split byte writes", 24'h0, wr_cnt);
    chk("split erases", 24'h0, er_cnt);
    chk("wel unused", 24'h1, write_enable_latch);
    $display("test off_boundary done");
    bp = 3'h1;
    hdr(8'h20, 24'h0F1000, 1'b1);
    u_sfpe_host.close_frame();
    hdr(8'h02, 24'h0F0000, 1'b1);
    u_sfpe_host.put_bits(8'h33, 8, 1'b0);
    u_sfpe_host.close_frame();
    simple(8'hC7);
    tsel = 1'b1;
    hdr(8'h20, 24'h00F000, 1'b1);
    u_sfpe_host.close_frame();
    u_sfpe_host.wt(20);
    chk("protected erases", 24'h0, er_cnt);
    chk("protected writes", 24'h0, wr_cnt);
    hdr(8'h20, 24'h0F1000, 1'b1);
    u_sfpe_host.close_frame();
    chk("unprotected erase", 24'h1, er_cnt);
    wait_idle();
    bp = 3'h0;
    tsel = 1'b0;
    $display("test protection done");
    for (int i = 0; i < 4; i++)
    begin
      clr();
      simple(8'h06);
      hdr(codes[i], 24'h034567, i < 2);
      u_sfpe_host.close_frame();
      chk("erase count", 24'h1, er_cnt);
      chk("erase kind", (i < 2) ? 24'(i) : 24'h2, er_kind);
      if (i < 2)
        chk("erase addr", 24'h034567, er_addr);
      if (i == 0)
      begin
        ce = 1'b0;
        u_sfpe_host.wt(40);
        chk("busy frozen", 24'h1, busy);
        ce = 1'b1;
      end
      wait_idle();
      chk("wel after erase", 24'h0, write_enable_latch);
    end
    $display("test erase_codes done");
    hdr(8'h3B, 24'h00FFFE, 1'b1);
    u_sfpe_host.put_bits(8'hA5, 8, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      u_sfpe_host.get_byte(1'b1, b);
      chk("dual byte", rd_val(24'h00FFFE + 24'(i)),
        b);
      chk("io enable", 24'h1, io_oe);
    end
    u_sfpe_host.close_frame();
    chk("io released", 24'h0, io_oe);
    $display("test dual_read done");
    close_out();
  end
endmodule : sfpe_seq_tb_top
